// *** hdl/xcvr_status_defines.svh ***
// constants for the second transceiver status register block
// assumes: included by bare name from hdl/ sources only
`ifndef XCVR_STATUS_DEFINES_SVH
`define XCVR_STATUS_DEFINES_SVH

// ===================================================================
// register offsets (byte addresses on the plain register port)
`define ADDR_STATUS_TWO      8'h08
`define ADDR_IRQ_STATUS      8'h20
`define ADDR_IRQ_MASK        8'h21
`define ADDR_TX_GUARD        8'h22
`define ADDR_RX_GUARD        8'h23
`define ADDR_MODE_CTRL       8'h24
`define ADDR_FRAME_BITS      8'h0d

// ===================================================================
// transceiver_status_two field positions; transmit go sits in the frame bits register
`define BIT_THERM_CLEAR      7
`define BIT_FORCE_FAST       6
`define BIT_TARGET_SEL       4
`define BIT_CIPHER_ON        3
`define BIT_TRANSMIT_GO      7
`define STATUS_TWO_RESET     8'h00

// mode control fields
`define BIT_TX_WAIT_FIELD    0
`define BIT_RX_WAIT_FIELD    1
`define BIT_RW_CIPHER_MODE   2

// interrupt status bits
`define IRQ_TARGET_SEL       0
`define IRQ_CIPHER_ON        1
`define IRQ_MODEM_IDLE       2
`define IRQ_THERM_CLEARED    3
`define IRQ_WIDTH            4

// ===================================================================
// modem state codes
`define MODEM_IDLE           3'h0
`define MODEM_WAIT_GO        3'h1
`define MODEM_TX_GUARD       3'h2
`define MODEM_SENDING        3'h3
`define MODEM_RX_GUARD       3'h4
`define MODEM_WAIT_DATA      3'h5
`define MODEM_RECEIVING      3'h6

`endif

// *** hdl/xcvr_status_pkg.sv ***
// types shared by the transceiver status block
// assumes: compiled before every module that names it
package xcvr_status_pkg;

  // one-hot modem observer states
  typedef enum logic [6:0] {
    st_idle      = 7'h01,
    st_wait_go   = 7'h02,
    st_tx_guard  = 7'h04,
    st_sending   = 7'h08,
    st_rx_guard  = 7'h10,
    st_wait_data = 7'h20,
    st_receiving = 7'h40
  } modem_state_t;

endpackage

// *** hdl/sync_two_ff.sv ***
// two flip-flop synchroniser for one level input
// assumes: input is asynchronous to clk_sys; rst synchronous
`timescale 1ns/1ns
module sync_two_ff (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage_one;

  // ===================================================================
  // synchroniser; the first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_one <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule

// *** hdl/guard_timer.sv ***
// minimum-time counter for a guard phase of the modem observer
// assumes: start is a one-cycle pulse on entry to the phase
`timescale 1ns/1ns
module guard_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] guard_cycles,
  output logic            elapsed
);
  logic [7:0] count;

  assign elapsed = (count == 8'h00) && !start;

  // ===================================================================
  // loads the programmed minimum, counts down to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= 8'h00;
    end else if (start) begin
      count <= guard_cycles;
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end
endmodule

// *** hdl/xcvr_status_two.sv ***
// What this block does
// - writing one to thermal clear drops the error only below the limit.
// - host filter runs fast with force fast set, else at protocol speed.
// - target selected sets once a select or polling command is answered.
// - that flag sets only while auto anticollision runs in passive mode.
// - target selected clears itself when the external field goes away.
// - cipher flag reads one while the unit is on, encrypting card traffic.
// - only a successful authenticate sets the cipher flag, no host write.
// - the cipher flag means something only in reader/writer cipher mode.
// - 000 idle, 001 wait go, 011 sending, 101 wait data, 110 receiving.
// - code 010 is the tx guard, held for the field when so chosen.
// - code 100 is the rx guard, held for the field when so chosen.
// - each guard lasts at least its programmed minimum time.
// - the status register reads zero after reset.
// - bit 5 reads zero and ignores writes.
// - writing one to transmit go starts transmission and ends wait go.
// holds: the second status register, its flags and the modem observer
// assumes: one clock, transceiver events are clk_sys pulses,
// field and temperature inputs come from pins
`timescale 1ns/1ns
`include "xcvr_status_defines.svh"
module xcvr_status_two (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins from the analog side
  input  wire logic       field_present_pin,
  input  wire logic       temp_above_limit_pin,
  // events from the transceiver core, same clock
  input  wire logic       over_temp_event,
  input  wire logic       sel_answered,
  input  wire logic       auto_anticoll_active,
  input  wire logic       passive_mode,
  input  wire logic       authenticate_ok,
  input  wire logic       transceive_start,
  input  wire logic       transmit_done,
  input  wire logic       rx_frame_start,
  input  wire logic       rx_frame_done,
  input  wire logic       cmd_abort,
  // outputs
  output logic            host_filter_fast,
  output logic            cipher_encrypt_en,
  output logic            transmit_go_pulse,
  output logic            over_temperature_error,
  output logic            irq
);
  // ===================================================================
  // synchronised pins
  // both lag the outside world by two cycles, which the flags tolerate
  logic field_present;
  logic temp_above;

  sync_two_ff u_sync_field (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async_in(field_present_pin),
    .sync_out(field_present)
  );

  sync_two_ff u_sync_temp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async_in(temp_above_limit_pin),
    .sync_out(temp_above)
  );

  // ===================================================================
  // registers
  logic                    force_fast;
  logic                    target_selected_flag;
  logic                    stream_cipher_active;
  logic [7:0]              tx_guard_time;
  logic [7:0]              rx_guard_time;
  logic [2:0]              mode_ctrl;
  logic [`IRQ_WIDTH-1:0]   irq_status;
  logic [`IRQ_WIDTH-1:0]   irq_mask;
  logic [7:0]              rd_mux;
  xcvr_status_pkg::modem_state_t state;
  xcvr_status_pkg::modem_state_t next_state;
  logic [2:0]              modem_code;

  // address decode
  wire wr_status = reg_wr && (reg_addr == `ADDR_STATUS_TWO);
  wire wr_frame  = reg_wr && (reg_addr == `ADDR_FRAME_BITS);
  wire wr_istat  = reg_wr && (reg_addr == `ADDR_IRQ_STATUS);
  wire wr_imask  = reg_wr && (reg_addr == `ADDR_IRQ_MASK);
  wire wr_txg    = reg_wr && (reg_addr == `ADDR_TX_GUARD);
  wire wr_rxg    = reg_wr && (reg_addr == `ADDR_RX_GUARD);
  wire wr_mode   = reg_wr && (reg_addr == `ADDR_MODE_CTRL);

  // thermal clear refused while still hot
  wire therm_clear = wr_status && reg_wdata[`BIT_THERM_CLEAR]
                     && !temp_above;
  // transmit go is a strobe; the bit itself is never stored
  wire go_write    = wr_frame && reg_wdata[`BIT_TRANSMIT_GO];
  // select answered counts only in passive auto anticollision
  wire sel_event   = sel_answered && auto_anticoll_active
                     && passive_mode;
  // a zero ends encryption; a one written here has no effect
  wire cipher_host_clr = wr_status && !reg_wdata[`BIT_CIPHER_ON];
  wire cipher_valid    = mode_ctrl[`BIT_RW_CIPHER_MODE];

  // outputs to the rest of the transceiver; go counts only in wait go
  assign host_filter_fast  = force_fast;
  assign cipher_encrypt_en = stream_cipher_active && cipher_valid;
  assign transmit_go_pulse = go_write &&
                             (state == xcvr_status_pkg::st_wait_go);

  // ===================================================================
  // status flags; an event in a clearing cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      force_fast             <= 1'b0;
      target_selected_flag   <= 1'b0;
      stream_cipher_active   <= 1'b0;
      over_temperature_error <= 1'b0;
    end else begin
      if (wr_status) begin
        force_fast <= reg_wdata[`BIT_FORCE_FAST];
      end
      if (sel_event) begin
        target_selected_flag <= 1'b1;
      end else if (!field_present) begin
        target_selected_flag <= 1'b0;
      end
      if (authenticate_ok) begin
        stream_cipher_active <= 1'b1;
      end else if (cipher_host_clr) begin
        stream_cipher_active <= 1'b0;
      end
      if (over_temp_event) begin
        over_temperature_error <= 1'b1;
      end else if (therm_clear) begin
        over_temperature_error <= 1'b0;
      end
    end
  end

  // ===================================================================
  // software-owned configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_guard_time <= 8'h00;
      rx_guard_time <= 8'h00;
      mode_ctrl     <= 3'h0;
      irq_mask      <= '0;
    end else begin
      if (wr_txg)   tx_guard_time <= reg_wdata;
      if (wr_rxg)   rx_guard_time <= reg_wdata;
      if (wr_mode)  mode_ctrl     <= reg_wdata[2:0];
      if (wr_imask) irq_mask      <= reg_wdata[`IRQ_WIDTH-1:0];
    end
  end

  // ===================================================================
  // guard timers; the start pulse marks entry into each guard
  logic tx_guard_done;
  logic rx_guard_done;
  wire  tx_guard_start = (next_state == xcvr_status_pkg::st_tx_guard) &&
                         (state != xcvr_status_pkg::st_tx_guard);
  wire  rx_guard_start = (next_state == xcvr_status_pkg::st_rx_guard) &&
                         (state != xcvr_status_pkg::st_rx_guard);

  guard_timer u_tx_guard (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (tx_guard_start),
    .guard_cycles(tx_guard_time),
    .elapsed     (tx_guard_done)
  );

  guard_timer u_rx_guard (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (rx_guard_start),
    .guard_cycles(rx_guard_time),
    .elapsed     (rx_guard_done)
  );

  // a guard told to wait for the field holds until it is present
  wire tx_field_ok = field_present || !mode_ctrl[`BIT_TX_WAIT_FIELD];
  wire rx_field_ok = field_present || !mode_ctrl[`BIT_RX_WAIT_FIELD];

  // ===================================================================
  // modem observer next state; abort from any state returns to idle
  always_comb begin
    next_state = state;
    unique case (state)
      xcvr_status_pkg::st_idle: begin
        if (transceive_start) next_state = xcvr_status_pkg::st_wait_go;
      end
      xcvr_status_pkg::st_wait_go: begin
        if (go_write) next_state = xcvr_status_pkg::st_tx_guard;
      end
      xcvr_status_pkg::st_tx_guard: begin
        if (tx_guard_done && tx_field_ok) begin
          next_state = xcvr_status_pkg::st_sending;
        end
      end
      xcvr_status_pkg::st_sending: begin
        if (transmit_done) next_state = xcvr_status_pkg::st_rx_guard;
      end
      xcvr_status_pkg::st_rx_guard: begin
        if (rx_guard_done && rx_field_ok) begin
          next_state = xcvr_status_pkg::st_wait_data;
        end
      end
      xcvr_status_pkg::st_wait_data: begin
        if (rx_frame_start) next_state = xcvr_status_pkg::st_receiving;
      end
      xcvr_status_pkg::st_receiving: begin
        if (rx_frame_done) next_state = xcvr_status_pkg::st_idle;
      end
      default: next_state = xcvr_status_pkg::st_idle;
    endcase
    if (cmd_abort) next_state = xcvr_status_pkg::st_idle;
  end

  // state register; reset and abort both land in idle
  always_ff @(posedge clk_sys) begin
    if (rst) state <= xcvr_status_pkg::st_idle;
    else     state <= next_state;
  end

  // ===================================================================
  // state code; 111 has no source so it is never shown
  always_comb begin
    unique case (state)
      xcvr_status_pkg::st_idle:      modem_code = `MODEM_IDLE;
      xcvr_status_pkg::st_wait_go:   modem_code = `MODEM_WAIT_GO;
      xcvr_status_pkg::st_tx_guard:  modem_code = `MODEM_TX_GUARD;
      xcvr_status_pkg::st_sending:   modem_code = `MODEM_SENDING;
      xcvr_status_pkg::st_rx_guard:  modem_code = `MODEM_RX_GUARD;
      xcvr_status_pkg::st_wait_data: modem_code = `MODEM_WAIT_DATA;
      xcvr_status_pkg::st_receiving: modem_code = `MODEM_RECEIVING;
      default:                       modem_code = `MODEM_IDLE;
    endcase
  end

  // ===================================================================
  // interrupts: sticky, write one to clear, set wins
  // a clear that meets a new alarm loses, so it raises no interrupt
  wire therm_cleared = therm_clear && over_temperature_error
                       && !over_temp_event;

  wire [`IRQ_WIDTH-1:0] irq_events = {
    therm_cleared,
    rx_frame_done && (state == xcvr_status_pkg::st_receiving),
    authenticate_ok,
    sel_event
  };

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi++) begin : g_irq
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          irq_status[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (wr_istat && reg_wdata[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // level output, high while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // ===================================================================
  // read mux; bit 5 and bit 7 of the status word read zero
  wire [7:0] status_word = {1'b0, force_fast, 1'b0,
                            target_selected_flag, stream_cipher_active,
                            modem_code};

  // register select; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      `ADDR_STATUS_TWO: rd_mux = status_word;
      `ADDR_IRQ_STATUS: rd_mux = {4'h0, irq_status};
      `ADDR_IRQ_MASK:   rd_mux = {4'h0, irq_mask};
      `ADDR_TX_GUARD:   rd_mux = tx_guard_time;
      `ADDR_RX_GUARD:   rd_mux = rx_guard_time;
      `ADDR_MODE_CTRL:  rd_mux = {5'h00, mode_ctrl};
      default:          rd_mux = 8'h00; // unmapped reads zero
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst)         reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 8'h00;
  end
endmodule

// *** test/xcvr_status_two_chk.sv ***
// port assertions for the second status register block
// assumes: bound into xcvr_status_two, one clock, rst synchronous
`timescale 1ns/1ns
module xcvr_status_two_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       over_temp_event,
  input wire logic       authenticate_ok,
  input wire logic       host_filter_fast,
  input wire logic       cipher_encrypt_en,
  input wire logic       transmit_go_pulse,
  input wire logic       over_temperature_error
);
  // ==================================================================
  // helpers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a read of the status word at 08h
  wire rd_st = reg_rd && reg_addr == 8'h08;
  // ==================================================================
  // properties
  property p_idle_rdata;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("read data not zero outside a read");
  property p_no_code7;
    $past(rd_st) |-> reg_rdata[2:0] != 3'h7;
  endproperty
  a_no_code7: assert property (p_no_code7)
    else $error("state code 111 reported");
  property p_zero_bits;
    $past(rd_st) |-> !reg_rdata[5] && !reg_rdata[7];
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("bit 5 or 7 of status reads one");
  property p_fast_wr;
    reg_wr && reg_addr == 8'h08 |=> host_filter_fast == $past(reg_wdata[6]);
  endproperty
  a_fast_wr: assert property (p_fast_wr)
    else $error("force fast output not written");
  property p_fast_rd;
    $past(rd_st) |-> reg_rdata[6] == $past(host_filter_fast);
  endproperty
  a_fast_rd: assert property (p_fast_rd)
    else $error("force fast bit reads wrong");
  property p_temp_set;
    over_temp_event |=> over_temperature_error;
  endproperty
  a_temp_set: assert property (p_temp_set)
    else $error("over temperature not latched");
  property p_temp_keep;
    over_temperature_error && !reg_wr |=> over_temperature_error;
  endproperty
  a_temp_keep: assert property (p_temp_keep)
    else $error("over temperature dropped without a write");
  property p_cipher_src;
    $rose(cipher_encrypt_en) |-> $past(authenticate_ok) || $past(reg_wr);
  endproperty
  a_cipher_src: assert property (p_cipher_src)
    else $error("cipher turned on without a cause");
  property p_go_src;
    transmit_go_pulse |-> reg_wr && reg_addr == 8'h0d && reg_wdata[7];
  endproperty
  a_go_src: assert property (p_go_src)
    else $error("transmit go without its write");
  // ==================================================================
  // coverage of the main scenarios
  c_go: cover property (transmit_go_pulse);
  c_temp: cover property (over_temp_event);
  c_cipher: cover property ($rose(cipher_encrypt_en));
endmodule

bind xcvr_status_two xcvr_status_two_chk u_chk (
  .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .over_temp_event, .authenticate_ok, .host_filter_fast,
  .cipher_encrypt_en, .transmit_go_pulse, .over_temperature_error);

// *** test/host_model.sv ***
// host side of the plain register port
// assumes: slave answers reads one cycle later and never stalls
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ==================================================================
  // bus cycles; strobes last one edge, then one idle edge follows
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just then
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// *** test/xcvr_status_two_tb.sv ***
// self-checking bench for the second status register block
// assumes: host_model drives the register port, events come from here
`timescale 1ns/1ns
module xcvr_status_two_tb;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic       reg_wr, reg_rd, fast, enc, go, terr, irq;
  logic       fld = 1'b0, hot = 1'b0, anti = 1'b0, pas = 1'b0;
  logic [7:0] ev = 8'h00;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         n;
  always #20 clk_sys = ~clk_sys;
  host_model u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  // event bits: temp, sel, auth, start, txdone, rxstart, rxdone, abort
  xcvr_status_two DUT (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .field_present_pin(fld),
    .temp_above_limit_pin(hot), .over_temp_event(ev[0]),
    .sel_answered(ev[1]), .auto_anticoll_active(anti),
    .passive_mode(pas), .authenticate_ok(ev[2]),
    .transceive_start(ev[3]), .transmit_done(ev[4]),
    .rx_frame_start(ev[5]), .rx_frame_done(ev[6]), .cmd_abort(ev[7]),
    .host_filter_fast(fast), .cipher_encrypt_en(enc),
    .transmit_go_pulse(go), .over_temperature_error(terr), .irq(irq));
  // ==================================================================
  // shared helpers
  task give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= 8'h00;
  endtask
  // polls the state code; a code that never comes ends the run
  task wait_code(input logic [2:0] c);
    for (n = 0; n < 60; n++) begin
      u_host.rd(8'h08, rv);
      if (rv[2:0] === c)
        return;
    end
    chk({5'h00, rv[2:0]}, {5'h00, c});
    give_verdict();
  endtask
  // ==================================================================
  // scenarios
  task t_reset();
    rchk(8'h08, 8'h00);
    rchk(8'h7f, 8'h00);
    chk({3'h0, fast, enc, go, terr, irq}, 8'h00);
  endtask
  task t_fast();
    u_host.wr(8'h08, 8'hff);
    rchk(8'h08, 8'h40);
    chk({7'h0, fast}, 8'h01);
    u_host.wr(8'h08, 8'h00);
    rchk(8'h08, 8'h00);
    chk({7'h0, fast}, 8'h00);
  endtask
  // a clear while still hot must be ignored
  task t_temp();
    @(posedge clk_sys) hot <= 1'b1;
    pulse(0);
    u_host.wr(8'h08, 8'h80);
    rchk(8'h08, 8'h00);
    chk({7'h0, terr}, 8'h01);
    @(posedge clk_sys) hot <= 1'b0;
    repeat (3) @(posedge clk_sys);
    u_host.wr(8'h08, 8'h80);
    rchk(8'h08, 8'h00);
    chk({7'h0, terr}, 8'h00);
  endtask
  task t_target();
    @(posedge clk_sys) fld <= 1'b1;
    pulse(1);
    rchk(8'h08, 8'h00);
    @(posedge clk_sys) anti <= 1'b1;
    pulse(1);
    rchk(8'h08, 8'h00);
    @(posedge clk_sys) pas <= 1'b1;
    pulse(1);
    rchk(8'h08, 8'h10);
    @(posedge clk_sys) fld <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rchk(8'h08, 8'h00);
  endtask
  task t_cipher();
    u_host.wr(8'h08, 8'h08);
    rchk(8'h08, 8'h00);
    pulse(2);
    rchk(8'h08, 8'h08);
    chk({7'h0, enc}, 8'h00);
    u_host.wr(8'h24, 8'h04);
    rchk(8'h08, 8'h08);
    chk({7'h0, enc}, 8'h01);
    u_host.wr(8'h08, 8'h00);
    rchk(8'h08, 8'h00);
    chk({7'h0, enc}, 8'h00);
  endtask
  // both guards wait for the field; the receive guard is timed
  task t_modem();
    u_host.wr(8'h22, 8'h04);
    u_host.wr(8'h23, 8'h0a);
    u_host.wr(8'h24, 8'h03);
    pulse(3);
    rchk(8'h08, 8'h01);
    pulse(7);
    rchk(8'h08, 8'h00);
    u_host.wr(8'h0d, 8'h80);
    rchk(8'h08, 8'h00);
    pulse(3);
    fork
      u_host.wr(8'h0d, 8'h80);
      begin
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({7'h0, go}, 8'h01);
      end
    join
    rchk(8'h08, 8'h02);
    repeat (20) @(posedge clk_sys);
    rchk(8'h08, 8'h02);
    @(posedge clk_sys) fld <= 1'b1;
    wait_code(3'h3);
    pulse(4);
    rchk(8'h08, 8'h04);
    wait_code(3'h5);
    chk({7'h0, n >= 3}, 8'h01);
    pulse(5);
    rchk(8'h08, 8'h06);
    pulse(6);
    rchk(8'h08, 8'h00);
    chk({7'h0, irq}, 8'h00);
    u_host.wr(8'h21, 8'h04);
    rchk(8'h20, 8'h0f);
    chk({7'h0, irq}, 8'h01);
    u_host.wr(8'h20, 8'h0f);
    rchk(8'h20, 8'h00);
    chk({7'h0, irq}, 8'h00);
  endtask
  // ==================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_fast();
    t_temp();
    t_target();
    t_cipher();
    t_modem();
    give_verdict();
  end
endmodule
